// ==== hdl/psbl_defs.svh ====
// Operation
// (RULE_01) legacy code 101 wraps inside an aligned 32-word group
// (RULE_02) legacy code 110 wraps inside an aligned 8-word group
// (RULE_03) legacy code 111 wraps inside an aligned 16-word group
// (RULE_04) legacy code 100 wraps inside an aligned 64-word group
// (RULE_05) hybrid codes wrap once, then run linear from past the group end
// (RULE_06) linear-select bit set: plain increment, burst code ignored
// (RULE_07) initial latency of 3 to 6 clocks from config, 6 after reset
// (RULE_08) pending refresh at start drives strobe high, adds a latency period
// (RULE_09) register writes take data right after command-address, no latency
// (RULE_10) refresh may run while register write data is captured
// (RULE_11) fixed latency: strobe always high, two latency periods
// (RULE_12) fixed latency is enabled after any reset
// (RULE_13) variable latency: strobe high only when refresh needs extra period
// (RULE_14) three-bit drive strength field, reset value 000b
// (RULE_15) clearing power-down-enable enters deep low power, refresh halts
// (RULE_16) array data counts as invalid after deep low power
// (RULE_17) chip-select pulse or reset leaves deep low power after exit time; rst_i returns to normal at once, with no exit time
// (RULE_18) latency codes 0000=5, 0001=6, 1110=3, 1111=4 clocks
// (RULE_19) burst length 00=128, 01=64, 10=16, 11=32 bytes, reset 32
// (RULE_20) hybrid-enable bit: 0 hybrid, 1 legacy wrap, set after reset
// (RULE_21) reserved latency codes are treated as six clocks
`ifndef PSBL_DEFS_SVH
`define PSBL_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define PSBL_ADR_W          4
`define PSBL_REG_CONFIG     4'h0
`define PSBL_REG_STATUS     4'h4
`define PSBL_CFG_RESET      16'h8F1F
`define PSBL_CFG_PDE        15
`define PSBL_CFG_DRV_HI     14
`define PSBL_CFG_DRV_LO     12
`define PSBL_CFG_LAT_HI     7
`define PSBL_CFG_LAT_LO     4
`define PSBL_CFG_FIXED      3
`define PSBL_CFG_LEGACY     2
`define PSBL_CFG_BLEN_HI    1
`define PSBL_ST_DEEP        0
`define PSBL_ST_ENTER       1
`define PSBL_ST_EXIT        2
`define PSBL_ST_LOST        3

// ****************************************
// command-address fields
// ****************************************
`define PSBL_CA_READ        47
`define PSBL_CA_REGSPACE    46
`define PSBL_CA_LINEAR      45
`define PSBL_CA_BYTES       3'h5

// ****************************************
// timing
// ****************************************
`define PSBL_CLK_MHZ        125
`define PSBL_ENTRY_NS       3000
`define PSBL_EXIT_NS        150000
`define PSBL_ENTRY_CYC      ((`PSBL_ENTRY_NS * `PSBL_CLK_MHZ) / 1000)
`define PSBL_EXIT_CYC       ((`PSBL_EXIT_NS * `PSBL_CLK_MHZ + 999) / 1000)

`endif

// ==== hdl/psbl_pkg.sv ====
package psbl_pkg;
  typedef enum logic [2:0] {
    PSBL_IDLE,
    PSBL_CA,
    PSBL_LAT,
    PSBL_DATA,
    PSBL_REGW,
    PSBL_DONE
  } psbl_link_e;

  typedef enum logic [1:0] {
    PSBL_NORMAL,
    PSBL_ENTER,
    PSBL_DEEP,
    PSBL_EXIT
  } psbl_pwr_e;
endpackage

// ==== hdl/psbl_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module psbl_seq #(
  parameter int ADDR_W = 22
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              load_i,
  input  wire logic [ADDR_W-1:0] start_i,
  input  wire logic              linear_i,
  input  wire logic              legacy_i,
  input  wire logic [1:0]        blen_i,
  input  wire logic              step_i,
  output logic      [ADDR_W-1:0] addr_o
);
  logic [ADDR_W-1:0] addr_q, addr_d, mask, lmask, base_q, base_d;
  logic [5:0]        cnt_q, cnt_d;
  logic              done_q, done_d, lin_q, lin_d;
  logic [1:0]        bl_q, bl_d;

  always_comb begin
    unique case (bl_q)
      2'b00: mask = {{(ADDR_W-6){1'b0}}, 6'h3F};
      2'b01: mask = {{(ADDR_W-6){1'b0}}, 6'h1F};
      2'b10: mask = {{(ADDR_W-6){1'b0}}, 6'h07};
      2'b11: mask = {{(ADDR_W-6){1'b0}}, 6'h0F};
    endcase
  end

  // group of the burst being loaded, not of the one before it
  always_comb begin
    unique case (blen_i)
      2'b00: lmask = {{(ADDR_W-6){1'b0}}, 6'h3F};
      2'b01: lmask = {{(ADDR_W-6){1'b0}}, 6'h1F};
      2'b10: lmask = {{(ADDR_W-6){1'b0}}, 6'h07};
      2'b11: lmask = {{(ADDR_W-6){1'b0}}, 6'h0F};
    endcase
  end

  always_comb begin
    addr_d = addr_q;
    base_d = base_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    lin_d  = lin_q;
    bl_d   = bl_q;
    if (load_i) begin
      addr_d = start_i;
      cnt_d  = 6'h00;
      bl_d   = blen_i;
      lin_d  = linear_i;
      done_d = legacy_i;
    end else if (step_i) begin
      cnt_d = cnt_q + 6'h01;
      if (lin_q) begin
        addr_d = addr_q + 1'b1; // [RULE_06]
      end else if (!done_q && cnt_q == mask[5:0]) begin
        // group fully visited once: carry on past its end
        addr_d = (base_q | mask) + 1'b1; // [RULE_05]
        done_d = 1'b1;
        lin_d  = 1'b1;
      end else begin
        addr_d = (addr_q & ~mask) | ((addr_q + 1'b1) & mask); // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
      end
    end
    if (load_i) begin
      base_d = start_i & ~lmask; // [RULE_05]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      base_q <= '0;
      cnt_q  <= 6'h00;
      done_q <= 1'b1;
      lin_q  <= 1'b0;
      bl_q   <= 2'b11;
    end else if (ce_i) begin
      addr_q <= addr_d;
      base_q <= base_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      lin_q  <= lin_d;
      bl_q   <= bl_d;
    end
  end

  assign addr_o = addr_q;

  a_wrap_stays_in: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
    (ce_i && step_i && !load_i && !lin_q && done_q)
    |=> ((addr_q & ~mask) == ($past(addr_q) & ~mask)))
    else $error("wrapped burst left its group");

  a_linear_incr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
    (ce_i && step_i && !load_i && lin_q) |=> (addr_q == $past(addr_q) + 1'b1))
    else $error("linear burst did not increment");

  a_hybrid_jump: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
    (ce_i && step_i && !load_i && !lin_q && !done_q && cnt_q == mask[5:0])
    |=> (addr_q == (base_q | mask) + 1'b1) && lin_q)
    else $error("hybrid burst did not continue past its group");
endmodule
`default_nettype wire

// ==== hdl/psbl_top.sv ====
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psbl_defs.svh"
module psbl_top
  import psbl_pkg::*;
#(
  parameter int          ADDR_W   = 22,
  parameter int unsigned EXIT_CYC = `PSBL_EXIT_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`PSBL_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   link_cs_n_i,
  input  wire logic                   link_ck_i,
  input  wire logic [7:0]             link_dq_i,
  output logic      [7:0]             link_dq_o,
  output logic                        link_dq_oe_o,
  input  wire logic                   strobe_mask_line_i,
  output logic                        strobe_mask_line_o,
  output logic                        strobe_mask_line_oe_o,
  input  wire logic                   refresh_pending_i,
  output logic                        refresh_halt_o,
  output logic      [2:0]             drive_strength_o,
  output logic                        low_power_o,
  output logic                        data_lost_o,
  output logic                        mem_req_o,
  output logic                        mem_we_o,
  output logic      [ADDR_W-1:0]      mem_addr_o,
  output logic      [15:0]            mem_wdata_o,
  output logic      [1:0]             mem_wmask_o,
  input  wire logic [15:0]            mem_rdata_i
);
  localparam int unsigned PCW   = $clog2(EXIT_CYC + `PSBL_ENTRY_CYC + 1);
  localparam int          ENTRY = `PSBL_ENTRY_CYC;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       cs_m_q, cs_s_q, cs_p_q, ck_m_q, ck_s_q, ck_p_q;
  logic       sm_m_q, sm_s_q;
  logic [7:0] dq_m_q, dq_s_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
      ck_m_q <= 1'b0;
      ck_s_q <= 1'b0;
      ck_p_q <= 1'b0;
      sm_m_q <= 1'b0;
      sm_s_q <= 1'b0;
      dq_m_q <= 8'h00;
      dq_s_q <= 8'h00;
    end else if (ce_i) begin
      cs_m_q <= link_cs_n_i;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      ck_m_q <= link_ck_i;
      ck_s_q <= ck_m_q;
      ck_p_q <= ck_s_q;
      sm_m_q <= strobe_mask_line_i;
      sm_s_q <= sm_m_q;
      dq_m_q <= link_dq_i;
      dq_s_q <= dq_m_q;
    end
  end

  // both edges move a byte; the link clock must be well below clk_i
  logic ck_edge, cs_fall, cs_rise;
  assign ck_edge = ck_s_q ^ ck_p_q;
  assign cs_fall = cs_p_q & ~cs_s_q;
  assign cs_rise = ~cs_p_q & cs_s_q;

  // ****************************************
  // register bus
  // ****************************************
  logic        ack_q, ack_d, cfg_wr, st_wr;
  logic [31:0] dat_q, dat_d;
  logic [15:0] cfg_q, cfg_d;
  logic [3:0]  status;

  always_comb begin
    ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
    cfg_wr = ack_d & wb_we_i & (wb_adr_i == `PSBL_REG_CONFIG);
    st_wr  = ack_d & wb_we_i & (wb_adr_i == `PSBL_REG_STATUS) & wb_sel_i[0];
    dat_d  = 32'h0000_0000;
    if (ack_d && !wb_we_i) begin
      unique case (wb_adr_i)
        `PSBL_REG_CONFIG: dat_d = {16'h0000, cfg_q};
        `PSBL_REG_STATUS: dat_d = {28'h000_0000, status};
        default:          dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // latency decode
  // ****************************************
  function automatic logic [2:0] lat_clocks(input logic [3:0] code);
    unique case (code)
      4'h0:    lat_clocks = 3'h5; // [RULE_18]
      4'h1:    lat_clocks = 3'h6;
      4'hE:    lat_clocks = 3'h3;
      4'hF:    lat_clocks = 3'h4;
      default: lat_clocks = 3'h6; // [RULE_21]
    endcase
  endfunction

  logic [2:0] lat_c;
  logic       fixed_lat, blocked;
  assign lat_c     = lat_clocks(cfg_q[`PSBL_CFG_LAT_HI:`PSBL_CFG_LAT_LO]); // [RULE_07]
  assign fixed_lat = cfg_q[`PSBL_CFG_FIXED];

  // ****************************************
  // link engine
  // ****************************************
  psbl_link_e  st_q, st_d;
  logic [39:0] ca_q, ca_d;
  logic [47:0] ca_nx;
  logic [4:0]  cnt_q, cnt_d, lat_tot;
  logic        dbl_q, dbl_d, ph_q, ph_d, strobe_mask_line_q, strobe_mask_line_d, req_q, req_d;
  logic        rdp_q, rdp_d, isrd_q, isrd_d, isreg_q, isreg_d;
  logic [15:0] rd_q, rd_d, wd_q, wd_d;
  logic [1:0]  wm_q, wm_d;
  logic [7:0]  dqo_q, dqo_d;
  logic        seq_load, link_cfg_we;
  logic [ADDR_W-1:0] seq_start;

  assign ca_nx     = {ca_q, dq_s_q};
  assign seq_start = ADDR_W'({ca_nx[44:16], ca_nx[2:0]});
  assign lat_tot   = dbl_q ? {lat_c, 2'b00} : {1'b0, lat_c, 1'b0}; // [RULE_11] [RULE_13]

  always_comb begin
    st_d        = st_q;
    ca_d        = ca_q;
    cnt_d       = cnt_q;
    dbl_d       = dbl_q;
    ph_d        = ph_q;
    strobe_mask_line_d      = strobe_mask_line_q;
    rd_d        = rdp_q ? mem_rdata_i : rd_q;
    wd_d        = wd_q;
    wm_d        = wm_q;
    dqo_d       = dqo_q;
    isrd_d      = isrd_q;
    isreg_d     = isreg_q;
    req_d       = 1'b0;
    rdp_d       = 1'b0;
    seq_load    = 1'b0;
    link_cfg_we = 1'b0;
    if (cs_rise || blocked) begin
      st_d   = PSBL_IDLE;
      strobe_mask_line_d = 1'b0;
    end else begin
      unique case (st_q)
        PSBL_IDLE: if (cs_fall) begin
          st_d  = PSBL_CA;
          cnt_d = 5'h00;
          dbl_d = fixed_lat | refresh_pending_i; // [RULE_08] [RULE_11] [RULE_13]
        end
        PSBL_CA: if (ck_edge) begin
          ca_d  = ca_nx[39:0];
          cnt_d = cnt_q + 5'h01;
          if (cnt_q[2:0] == `PSBL_CA_BYTES) begin
            isrd_d   = ca_nx[`PSBL_CA_READ];
            isreg_d  = ca_nx[`PSBL_CA_REGSPACE];
            seq_load = 1'b1;
            cnt_d    = 5'h00;
            ph_d     = 1'b0;
            // register writes skip latency whatever the strobe showed
            st_d     = (!ca_nx[`PSBL_CA_READ] && ca_nx[`PSBL_CA_REGSPACE]) ?
                       PSBL_REGW : PSBL_LAT; // [RULE_09]
          end
        end
        PSBL_LAT: if (ck_edge) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q + 5'h01 == lat_tot) begin // [RULE_07]
            st_d   = PSBL_DATA;
            strobe_mask_line_d = 1'b0;
            if (isrd_q && isreg_q) begin
              rd_d = cfg_q;
            end else if (isrd_q) begin
              req_d = 1'b1;
              rdp_d = 1'b1;
            end
          end
        end
        PSBL_DATA: if (ck_edge) begin
          ph_d = ~ph_q;
          if (isrd_q) begin
            dqo_d  = ph_q ? rd_q[7:0] : rd_q[15:8];
            strobe_mask_line_d = ~ph_q;
            if (ph_q && !isreg_q) begin
              req_d = 1'b1;
              rdp_d = 1'b1;
            end
          end else if (!ph_q) begin
            wd_d[15:8] = dq_s_q;
            wm_d[1]    = sm_s_q;
          end else begin
            wd_d[7:0]  = dq_s_q;
            wm_d[0]    = sm_s_q;
            req_d      = 1'b1;
          end
        end
        PSBL_REGW: if (ck_edge) begin
          // refresh is never waited on here
          ph_d = ~ph_q; // [RULE_10]
          if (!ph_q) begin
            wd_d[15:8] = dq_s_q;
          end else begin
            wd_d[7:0]   = dq_s_q;
            link_cfg_we = 1'b1; // [RULE_09]
            st_d        = PSBL_DONE;
          end
        end
        PSBL_DONE: st_d = PSBL_DONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= PSBL_IDLE;
      ca_q    <= 40'h00_0000_0000;
      cnt_q   <= 5'h00;
      dbl_q   <= 1'b1;
      ph_q    <= 1'b0;
      strobe_mask_line_q  <= 1'b0;
      req_q   <= 1'b0;
      rdp_q   <= 1'b0;
      isrd_q  <= 1'b0;
      isreg_q <= 1'b0;
      rd_q    <= 16'h0000;
      wd_q    <= 16'h0000;
      wm_q    <= 2'b00;
      dqo_q   <= 8'h00;
    end else if (ce_i) begin
      st_q    <= st_d;
      ca_q    <= ca_d;
      cnt_q   <= cnt_d;
      dbl_q   <= dbl_d;
      ph_q    <= ph_d;
      strobe_mask_line_q  <= strobe_mask_line_d;
      req_q   <= req_d;
      rdp_q   <= rdp_d;
      isrd_q  <= isrd_d;
      isreg_q <= isreg_d;
      rd_q    <= rd_d;
      wd_q    <= wd_d;
      wm_q    <= wm_d;
      dqo_q   <= dqo_d;
    end
  end

  // address advances the cycle after each request, so the request sees the old one
  psbl_seq #(
    .ADDR_W (ADDR_W)
  ) u_seq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .load_i   (seq_load),
    .start_i  (seq_start),
    .linear_i (ca_nx[`PSBL_CA_LINEAR]),
    .legacy_i (cfg_q[`PSBL_CFG_LEGACY]),
    .blen_i   (cfg_q[`PSBL_CFG_BLEN_HI:0]),
    .step_i   (req_q),
    .addr_o   (mem_addr_o)
  );

  assign mem_req_o             = req_q;
  assign mem_we_o              = ~isrd_q;
  assign mem_wdata_o           = wd_q;
  assign mem_wmask_o           = wm_q;
  assign link_dq_o             = dqo_q;
  assign link_dq_oe_o          = (st_q == PSBL_DATA) & isrd_q;
  assign strobe_mask_line_oe_o = (st_q == PSBL_CA) | link_dq_oe_o;
  assign strobe_mask_line_o    = (st_q == PSBL_CA) ? dbl_q : strobe_mask_line_q; // [RULE_08]

  // ****************************************
  // configuration and power
  // ****************************************
  psbl_pwr_e pw_q, pw_d;
  logic [PCW-1:0] pc_q, pc_d;
  logic           lost_q, lost_d;

  always_comb begin
    cfg_d  = cfg_q;
    pw_d   = pw_q;
    pc_d   = pc_q;
    lost_d = lost_q;
    if (cfg_wr && wb_sel_i[0]) begin
      cfg_d[7:0] = wb_dat_i[7:0];
    end
    if (cfg_wr && wb_sel_i[1]) begin
      cfg_d[15:8] = wb_dat_i[15:8];
    end
    if (link_cfg_we) begin
      cfg_d = wd_d;
    end
    if (st_wr && wb_dat_i[`PSBL_ST_LOST]) begin
      lost_d = 1'b0;
    end
    unique case (pw_q)
      PSBL_NORMAL: if (!cfg_q[`PSBL_CFG_PDE]) begin
        pw_d = PSBL_ENTER; // [RULE_15]
        pc_d = '0;
      end
      PSBL_ENTER: begin
        pc_d = pc_q + 1'b1;
        // counted from the write edge, which already spent one clock
        if (pc_q == PCW'(ENTRY - 2)) begin
          pw_d = PSBL_DEEP;
        end
      end
      PSBL_DEEP: if (cs_rise) begin
        pw_d = PSBL_EXIT; // [RULE_17]
        pc_d = '0;
      end
      PSBL_EXIT: begin
        pc_d = pc_q + 1'b1;
        if (pc_q == PCW'(EXIT_CYC - 1)) begin
          pw_d                 = PSBL_NORMAL; // [RULE_17]
          cfg_d[`PSBL_CFG_PDE] = 1'b1;
        end
      end
    endcase
    // contents decay without refresh; set beats a same-cycle clear
    if (pw_q == PSBL_DEEP) begin
      lost_d = 1'b1; // [RULE_16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q  <= `PSBL_CFG_RESET; // [RULE_12] [RULE_14] [RULE_19] [RULE_20] [RULE_07]
      pw_q   <= PSBL_NORMAL;
      pc_q   <= '0;
      lost_q <= 1'b0;
    end else if (ce_i) begin
      cfg_q  <= cfg_d;
      pw_q   <= pw_d;
      pc_q   <= pc_d;
      lost_q <= lost_d;
    end
  end

  assign blocked          = (pw_q != PSBL_NORMAL) | ~cfg_q[`PSBL_CFG_PDE];
  assign status           = {lost_q, pw_q == PSBL_EXIT, pw_q == PSBL_ENTER, pw_q == PSBL_DEEP};
  assign refresh_halt_o   = (pw_q == PSBL_DEEP); // [RULE_15]
  assign low_power_o      = (pw_q == PSBL_DEEP);
  assign data_lost_o      = lost_q;
  assign drive_strength_o = cfg_q[`PSBL_CFG_DRV_HI:`PSBL_CFG_DRV_LO]; // [RULE_14]

  // ****************************************
  // checks
  // ****************************************
  sequence s_txn_start;
    ce_i && st_q == PSBL_IDLE && cs_fall && !cs_rise && !blocked;
  endsequence

  sequence s_ca_phase;
    st_q == PSBL_CA && strobe_mask_line_oe_o;
  endsequence

  a_fixed_strobe: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_11]
    (s_txn_start and fixed_lat) |=> (s_ca_phase and strobe_mask_line_o))
    else $error("fixed latency strobe not high");

  a_refresh_strobe: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
    (s_txn_start and (!fixed_lat && !refresh_pending_i)) |=> (s_ca_phase and !strobe_mask_line_o))
    else $error("strobe high with no refresh pending");

  a_reset_config: assert property (@(posedge clk_i) // [RULE_12]
    $past(rst_i) |-> (cfg_q == `PSBL_CFG_RESET && drive_strength_o == 3'h0))
    else $error("config not at reset value");

  a_latency_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_18]
    (cfg_q[7:4] == 4'hE) |-> (lat_c == 3'h3))
    else $error("latency code 1110 not three clocks");

  a_regw_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
    (ce_i && st_q == PSBL_REGW && ck_edge && ph_q && !cs_rise && !blocked)
    |=> (cfg_q == {$past(wd_q[15:8]), $past(dq_s_q)}) && st_q == PSBL_DONE)
    else $error("register write data not captured");

  a_dlp_entry: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // [RULE_15]
    (pw_q == PSBL_NORMAL && !cfg_q[`PSBL_CFG_PDE]) |-> ##[1:ENTRY] (pw_q == PSBL_DEEP))
    else $error("deep low power not entered in time");

  a_dlp_lost: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_16]
    (ce_i && pw_q == PSBL_DEEP) |=> lost_q)
    else $error("data not marked lost");

  a_dlp_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_17]
    (ce_i && pw_q == PSBL_DEEP && cs_rise) |=> (pw_q == PSBL_EXIT && !refresh_halt_o))
    else $error("chip select pulse did not start exit");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ack_q) |=> !ack_q)
    else $error("bus ack longer than one cycle");
endmodule
`default_nettype wire

// ==== verif/psbl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host memory controller model
// ****************************************
module psbl_host (
  input  wire logic       clk_i,
  output logic            cs_n_o,
  output logic            ck_o,
  output logic [7:0]      dq_o,
  output logic            mask_o,
  input  wire logic       smask_i,
  input  wire logic       smask_oe_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       dq_oe_i
);
  logic       ca_strobe;
  logic [9:0] rb[$];
  initial begin
    cs_n_o = 1'b1;
    ck_o = 1'b0;
    dq_o = 8'h5A;
    mask_o = 1'b0;
    ca_strobe = 1'b0;
  end
  // data set up two clocks ahead of the edge, device oversamples
  task automatic step(input logic [7:0] b);
    dq_o <= b;
    repeat (2) @(posedge clk_i);
    ck_o <= ~ck_o;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic xfer(input logic [47:0] ca, input int lat, input int nb,
                      input logic [7:0] b0);
    int e;
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 5; i >= 0; i--) begin
      if (i == 0) ca_strobe = smask_oe_i & smask_i;
      step(ca[i*8 +: 8]);
    end
    e = 2 * lat * (ca_strobe ? 2 : 1);
    for (int i = 0; i < e; i++) step(~dq_o);
    // second byte masked; a register write must ignore it
    for (int i = 0; i < nb; i++) begin
      mask_o <= (i == 1);
      step(b0 + 8'(i));
      rb.push_back({dq_oe_i, smask_i, dq_i});
    end
    cs_n_o <= 1'b1;
    mask_o <= 1'b0;
    dq_o <= ~dq_o;
    repeat (8) @(posedge clk_i);
  endtask
  // wake-up pulse; caller waits out the exit time
  task automatic pulse();
    cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    cs_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/test_psbl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module test_psbl_top;
  logic        clk, rst, cyc, stb, we, ack, pend, lp, halt, lost, req, mwe;
  logic        cs_n, ck, msk, so, soe, dqoe;
  logic [1:0]  wm;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, r;
  logic [7:0]  dqi, dqo;
  logic [2:0]  drv;
  logic [21:0] maddr;
  logic [15:0] mwd;
  logic [22:0] aq[$];
  logic [17:0] wq[$];
  int          fails, check_count, tick, n;

  psbl_top #(.EXIT_CYC(20)) u_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_cs_n_i(cs_n), .link_ck_i(ck),
    .link_dq_i(dqi), .link_dq_o(dqo), .link_dq_oe_o(dqoe), .strobe_mask_line_i(msk),
    .strobe_mask_line_o(so), .strobe_mask_line_oe_o(soe),
    .refresh_pending_i(pend), .refresh_halt_o(halt), .drive_strength_o(drv),
    .low_power_o(lp), .data_lost_o(lost), .mem_req_o(req), .mem_we_o(mwe),
    .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_wmask_o(wm),
    .mem_rdata_i({maddr[7:0], ~maddr[7:0]}));
  psbl_host u_host (.clk_i(clk), .cs_n_o(cs_n), .ck_o(ck), .dq_o(dqi),
    .mask_o(msk), .smask_i(so), .smask_oe_i(soe), .dq_i(dqo), .dq_oe_i(dqoe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    tick <= tick + 1;
    if (req === 1'b1) begin
      aq.push_back({mwe, maddr});
      wq.push_back({wm, mwd});
    end
    if (tick == 30000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // word index i of a burst from start s; hybrid past the wrap is base + i
  function automatic int ea(input logic [2:0] c, input logic lin, input int s,
                            input int i);
    int w;
    int b;
    w = c[1] ? (c[0] ? 16 : 8) : (c[0] ? 32 : 64);
    b = s - (s % w);
    if (lin) return s + i;
    if (!c[2] && i >= w) return b + i;
    return b + (s - b + i) % w;
  endfunction
  task automatic run(input logic [15:0] c, input logic lin, input int s,
                     input int w, input int lat, input logic es);
    wb(1'b1, 4'h0, {16'h0, c});
    aq.delete();
    wq.delete();
    u_host.xfer({2'b00, lin, 29'(s >> 3), 13'h0, 3'(s)}, lat, 2 * w, 8'h00);
    chk(u_host.ca_strobe, es);
    chk(aq.size(), w);
    for (int i = 0; i < w; i++) begin
      chk(aq[i], 32'h400000 | ea(c[2:0], lin, s, i));
      chk(wq[i], {2'(i == 0), 8'(2 * i), 8'(2 * i + 1)});
    end
  endtask

  initial begin
    {rst, cyc, stb, we, adr, sel, wdat, pend} = {1'b1, 44'h0};
    {tick, fails, check_count} = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    chk(r, 32'h8F1F);
    chk(drv, 3'h0);
    run(16'h8FE4, 1'b0, 'h03, 66, 3, 1'b0);
    run(16'h8FE5, 1'b0, 'h2E, 33, 3, 1'b0);
    run(16'h8FE6, 1'b0, 'h02, 9, 3, 1'b0);
    run(16'h8FE7, 1'b0, 'h0A, 17, 3, 1'b0);
    run(16'h8FE2, 1'b0, 'h0C, 10, 3, 1'b0);
    run(16'h8FE3, 1'b0, 'h1E, 18, 3, 1'b0);
    run(16'h8FE6, 1'b1, 'h03, 20, 3, 1'b0);
    pend <= 1'b1;
    run(16'h8F0F, 1'b0, 'h05, 2, 5, 1'b1);
    run(16'h8F17, 1'b0, 'h05, 2, 6, 1'b1);
    pend <= 1'b0;
    run(16'h8FF7, 1'b0, 'h05, 2, 4, 1'b0);
    run(16'h8F2F, 1'b0, 'h05, 2, 6, 1'b1);
    // memory read from word 0F in an 8-word wrap, then a register read
    wb(1'b1, 4'h0, 32'h8FE6);
    u_host.rb.delete();
    u_host.xfer({3'b100, 29'h1, 13'h0, 3'h7}, 3, 4, 8'h00);
    u_host.xfer({2'b11, 46'h0}, 3, 2, 8'h00);
    chk(u_host.rb[0], 10'h30F);
    chk(u_host.rb[1], 10'h2F0);
    chk(u_host.rb[2], 10'h308);
    chk(u_host.rb[3], 10'h2F7);
    chk(u_host.rb[4], 10'h38F);
    chk(u_host.rb[5], 10'h2E6);
    // register write with refresh pending: no latency, no array access
    pend <= 1'b1;
    aq.delete();
    u_host.xfer({2'b01, 46'h0}, 0, 2, 8'hA3);
    chk(aq.size(), 0);
    wb(1'b0, 4'h0, 32'h0);
    chk(r, 32'hA3A4);
    chk(drv, 3'h2);
    pend <= 1'b0;
    wb(1'b1, 4'h0, 32'h0F1F);
    n = 0;
    while (lp !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(n > 360 && n < 385, 1);
    @(posedge clk);
    chk({halt, lost}, 2'b11);
    wb(1'b0, 4'h4, 32'h0);
    chk(r, 32'h9);
    wb(1'b0, 4'h8, 32'h0);
    chk(r, 32'h0);
    u_host.pulse();
    n = 0;
    r = 32'h1;
    // exit lasts EXIT_CYC clocks; each status read takes three
    while (r[2:0] != 3'h0 && n < 100) begin
      wb(1'b0, 4'h4, 32'h0);
      n++;
    end
    chk(n > 5 && n < 12, 1);
    chk(lp, 1'b0);
    wb(1'b0, 4'h0, 32'h0);
    chk(r, 32'h8F1F);
    chk(lost, 1'b1);
    wb(1'b1, 4'h4, 32'h8);
    chk(lost, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
